// ==== core/dbgc_top.sv ====
// Debug control register set with external debug mode gating
//
// Behaviour
// - With edm set, software writes to any debug register change nothing.
// - The edm bit is read-only to software; only the debug port writes it.
// - First setting of edm leaves all other control bits unchanged.
// - Reads need not be consistent during debugger access, except edm.
// - Edm resets on test, power-on, logic-reset state; others on processor reset.
// - Watchpoints come from compare setup even when the event is disabled.
// - Edm set: no interrupt vectoring; edm clear: no mapping to external events.
// - Idm clear blocks status updates unless edm; idm set lets enabled events record.
// - Idm and state debug enable give interrupt on new or recorded event.
// - Reset field value 10 asserts reset-out; 00 nothing; 01, 11 reserved.
// - Bits 4 to 7 enable complete, branch, interrupt and trap events.
// - Bits 8 to 11 enable the four instruction address compare events.
// - Data compare fields: 00 off, 01 stores, 10 loads, 11 both.
// - Bit 16 enables the return-from-interrupt event.
// - Bits 21 and 22 enable the two external input events.
// - Bits 25 and 26 enable critical interrupt and critical return events.
// - Bit-match mode: compare two and four mask compare one and three.
// - Bit-match mode: data compare two masks data compare one.
// - Instruction compares ignore the lowest address bit on both sides.
`timescale 1ns/10ps
module dbgc_top (
  input  wire logic               ref_clk,
  input  wire logic               arst_n,
  input  wire logic               proc_rst_n_pin,
  input  wire logic               test_rst_n_pin,
  input  wire logic               tap_logic_reset_pin,
  input  wire logic [1:0]         ext_evt_pin,
  input  wire dbgc_pkg::dbgc_req_s spr_req,
  input  wire dbgc_pkg::dbgc_req_s dp_req,
  input  wire dbgc_pkg::dbgc_evt_s core_evt,
  input  wire logic               machine_state_debug_enable,
  input  wire logic               fetch_valid,
  input  wire logic [31:0]        fetch_addr,
  input  wire logic               data_valid,
  input  wire logic               data_is_store,
  input  wire logic [31:0]        data_addr,
  output logic [31:0]             spr_rdata_q,
  output logic [31:0]             dp_rdata_q,
  output logic                    reset_out_n_q,
  output logic                    debug_int_q,
  output logic                    ext_debug_event_q,
  output logic [5:0]              watchpoint_q
);

  logic [dbgc_pkg::NREG-1:0][31:0] regs_q;
  logic [dbgc_pkg::NREG-1:0][31:0] regs_d;
  logic                            edm_q;
  logic                            edm_d;
  logic [dbgc_pkg::NPIN-1:0]       pin_lvl;
  logic [1:0]                      devt_prev_q;
  logic [1:0]                      devt_rise;
  logic                            test_clr;
  logic                            idm_q;
  logic [31:0]                     ctl0;
  logic [31:0]                     iaddr;
  logic [31:0]                     iac_m [4];
  logic [1:0]                      m12;
  logic [1:0]                      m34;
  logic [1:0]                      dm12;
  logic [3:0]                      ihit;
  logic [1:0]                      dhit;
  logic [31:0]                     ev_vec;
  logic [31:0]                     en_vec;
  logic [31:0]                     rec_vec;
  logic                            rec_on;
  logic [31:0]                     spr_rdata_d;
  logic [31:0]                     dp_rdata_d;
  logic                            reset_out_n_d;
  logic                            debug_int_d;
  logic                            ext_debug_event_d;
  logic [5:0]                      watchpoint_d;

  // Pins from outside the clock domain
  dbgc_pin_sync #(
    .W    (dbgc_pkg::NPIN),
    .IDLE (dbgc_pkg::PIN_IDLE)
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .pin_in  ({ext_evt_pin, tap_logic_reset_pin, test_rst_n_pin, proc_rst_n_pin}),
    .level_q (pin_lvl)
  );

  // Decoded views of the register set
  assign test_clr = !pin_lvl[dbgc_pkg::PIN_TEST] || pin_lvl[dbgc_pkg::PIN_TAP];
  assign ctl0     = regs_q[dbgc_pkg::SEL_CTL0];
  assign idm_q    = ctl0[dbgc_pkg::POS_IDM];
  assign m12      = regs_q[dbgc_pkg::SEL_CTL1][dbgc_pkg::POS_IM12 +: 2];
  assign m34      = regs_q[dbgc_pkg::SEL_CTL1][dbgc_pkg::POS_IM34 +: 2];
  assign dm12     = regs_q[dbgc_pkg::SEL_CTL2][dbgc_pkg::POS_DM12 +: 2];
  assign devt_rise = pin_lvl[dbgc_pkg::PIN_EV1 +: 2] & ~devt_prev_q;
  assign iaddr    = fetch_addr & dbgc_pkg::IADDR_KEEP;

  // Compare of one register pair; first selects the lower register
  function automatic logic pair_hit(
    input logic [1:0]  mode,
    input logic [31:0] addr,
    input logic [31:0] a,
    input logic [31:0] b,
    input logic        first
  );
    case (mode)
      dbgc_pkg::MODE_EXACT: return first ? (addr == a) : (addr == b);
      dbgc_pkg::MODE_BITM:  return first && ((addr & b) == (a & b));
      dbgc_pkg::MODE_INCL:  return first && (addr >= a) && (addr < b);
      dbgc_pkg::MODE_EXCL:  return first && ((addr < a) || (addr >= b));
      default:              return 1'b0;
    endcase
  endfunction : pair_hit

  // Read value of one register, edm merged into control zero
  function automatic logic [31:0] rd_word(
    input logic [dbgc_pkg::NREG-1:0][31:0] r,
    input logic                            external_debug_mode_bit,
    input dbgc_pkg::dbgc_sel_t             sel
  );
    if (sel == dbgc_pkg::SEL_CTL0)
      return r[dbgc_pkg::SEL_CTL0] | {31'h0000_0000, external_debug_mode_bit};
    else if (sel < dbgc_pkg::NREG)
      return r[sel];
    else
      return 32'h0000_0000;
  endfunction : rd_word

  // Masked instruction compare registers
  for (genvar i = 0; i < 4; i++)
  begin : g_iac
    assign iac_m[i] = regs_q[dbgc_pkg::SEL_INSTR_ADDR_COMPARE_ONE + i] & dbgc_pkg::IADDR_KEEP;
  end

  // Address compare hits, independent of event enables
  always_comb
  begin
    ihit[0] = fetch_valid && pair_hit(m12, iaddr, iac_m[0], iac_m[1], 1'b1);
    ihit[1] = fetch_valid && pair_hit(m12, iaddr, iac_m[0], iac_m[1], 1'b0);
    ihit[2] = fetch_valid && pair_hit(m34, iaddr, iac_m[2], iac_m[3], 1'b1);
    ihit[3] = fetch_valid && pair_hit(m34, iaddr, iac_m[2], iac_m[3], 1'b0);
    dhit[0] = data_valid && pair_hit(dm12, data_addr, regs_q[dbgc_pkg::SEL_DATA_ADDR_COMPARE_ONE],
                                     regs_q[dbgc_pkg::SEL_DATA_ADDR_COMPARE_TWO], 1'b1);
    dhit[1] = data_valid && pair_hit(dm12, data_addr, regs_q[dbgc_pkg::SEL_DATA_ADDR_COMPARE_ONE],
                                     regs_q[dbgc_pkg::SEL_DATA_ADDR_COMPARE_TWO], 1'b0);
  end

  // Event vector at status positions, gated by control zero enables
  always_comb
  begin
    ev_vec = 32'h0000_0000;
    ev_vec[dbgc_pkg::POS_INSTR_COMPLETE_EVENT_ENABLE]  = core_evt.instr_complete_event_enable;
    ev_vec[dbgc_pkg::POS_BRT]   = core_evt.branch_taken_event_enable;
    ev_vec[dbgc_pkg::POS_INTERRUPT_TAKEN_EVENT_ENABLE]  = core_evt.interrupt_taken_event_enable;
    ev_vec[dbgc_pkg::POS_TRAP]  = core_evt.trap;
    for (int i = 0; i < 4; i++)
      ev_vec[dbgc_pkg::POS_INSTR_ADDR_COMPARE_ONE + i] = ihit[i];
    ev_vec[dbgc_pkg::POS_DATA_ADDR_COMPARE_ONE]  = dhit[0] &&
      ((data_is_store && ctl0[dbgc_pkg::POS_DATA_ADDR_COMPARE_ONE]) ||
       (!data_is_store && ctl0[dbgc_pkg::POS_DATA_ADDR_COMPARE_ONE + 1]));
    ev_vec[dbgc_pkg::POS_DATA_ADDR_COMPARE_TWO]  = dhit[1] &&
      ((data_is_store && ctl0[dbgc_pkg::POS_DATA_ADDR_COMPARE_TWO]) ||
       (!data_is_store && ctl0[dbgc_pkg::POS_DATA_ADDR_COMPARE_TWO + 1]));
    ev_vec[dbgc_pkg::POS_RET]   = core_evt.ret;
    ev_vec[dbgc_pkg::POS_EXTERNAL_EVENT_ONE_ENABLE] = devt_rise[0];
    ev_vec[dbgc_pkg::POS_EXTERNAL_EVENT_TWO_ENABLE] = devt_rise[1];
    ev_vec[dbgc_pkg::POS_CRITICAL_INTERRUPT_EVENT_ENABLE] = core_evt.critical_interrupt_event_enable;
    ev_vec[dbgc_pkg::POS_CRITICAL_RETURN_EVENT_ENABLE]  = core_evt.critical_return_event_enable;
    // Single-bit enables sit at the event's own position
    en_vec = ctl0 & dbgc_pkg::STAT_MASK;
    en_vec[dbgc_pkg::POS_DATA_ADDR_COMPARE_ONE] = 1'b1;
    en_vec[dbgc_pkg::POS_DATA_ADDR_COMPARE_TWO] = 1'b1;
    rec_vec = ev_vec & en_vec;
    rec_on  = idm_q || edm_q;
  end

  // Register set next state: debugger, then software, then events, then resets
  always_comb
  begin
    regs_d = regs_q;
    edm_d  = edm_q;
    if (dp_req.wr)
    begin
      if (dp_req.sel == dbgc_pkg::SEL_CTL0)
      begin
        edm_d = dp_req.data[dbgc_pkg::POS_EDM];
        if (edm_q)
          regs_d[dbgc_pkg::SEL_CTL0] = dp_req.data & dbgc_pkg::CTL0_WR_MASK;
      end
      else if (edm_q && dp_req.sel == dbgc_pkg::SEL_STAT)
        regs_d[dbgc_pkg::SEL_STAT] = regs_q[dbgc_pkg::SEL_STAT] & ~dp_req.data;
      else if (edm_q && dp_req.sel < dbgc_pkg::NREG)
        regs_d[dp_req.sel] = dp_req.data;
    end
    else if (spr_req.wr && !edm_q)
    begin
      if (spr_req.sel == dbgc_pkg::SEL_CTL0)
        regs_d[dbgc_pkg::SEL_CTL0] = spr_req.data & dbgc_pkg::CTL0_WR_MASK;
      else if (spr_req.sel == dbgc_pkg::SEL_STAT)
        regs_d[dbgc_pkg::SEL_STAT] = regs_q[dbgc_pkg::SEL_STAT] & ~spr_req.data;
      else if (spr_req.sel < dbgc_pkg::NREG)
        regs_d[spr_req.sel] = spr_req.data;
    end
    // Recording after the clear, so a same-cycle event survives
    if (rec_on)
      regs_d[dbgc_pkg::SEL_STAT] = regs_d[dbgc_pkg::SEL_STAT] | rec_vec;
    if (!pin_lvl[dbgc_pkg::PIN_PROC])
      regs_d = '0;
    if (test_clr)
      edm_d = 1'b0;
  end

  // Output next values
  always_comb
  begin
    spr_rdata_d   = spr_req.rd ? rd_word(regs_q, edm_q, spr_req.sel) : spr_rdata_q;
    dp_rdata_d    = dp_req.rd ? rd_word(regs_q, edm_q, dp_req.sel) : dp_rdata_q;
    reset_out_n_d = ctl0[dbgc_pkg::POS_RST +: 2] != dbgc_pkg::RST_ASSERT;
    debug_int_d   = idm_q && machine_state_debug_enable && !edm_q &&
                    ((|regs_q[dbgc_pkg::SEL_STAT]) || (|rec_vec));
    ext_debug_event_d = edm_q && (|rec_vec);
    watchpoint_d  = {dhit, ihit};
  end

  // Register set; edm survives processor reset
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      regs_q      <= '0;
      edm_q       <= 1'b0;
      devt_prev_q <= 2'h0;
    end
    else
    begin
      regs_q      <= regs_d;
      edm_q       <= edm_d;
      devt_prev_q <= pin_lvl[dbgc_pkg::PIN_EV1 +: 2];
    end
  end

  // Output flops
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      spr_rdata_q       <= dbgc_pkg::REG_RESET;
      dp_rdata_q        <= dbgc_pkg::REG_RESET;
      reset_out_n_q     <= 1'b1;
      debug_int_q       <= 1'b0;
      ext_debug_event_q <= 1'b0;
      watchpoint_q      <= 6'h00;
    end
    else
    begin
      spr_rdata_q       <= spr_rdata_d;
      dp_rdata_q        <= dp_rdata_d;
      reset_out_n_q     <= reset_out_n_d;
      debug_int_q       <= debug_int_d;
      ext_debug_event_q <= ext_debug_event_d;
      watchpoint_q      <= watchpoint_d;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  chk_sw_write_blocked: assert property (
    (edm_q && spr_req.wr && !dp_req.wr && pin_lvl[dbgc_pkg::PIN_PROC])
      |=> $stable(regs_q[dbgc_pkg::SEL_CTL0]))
    else $error("software write changed control while edm set");

  chk_edm_sw_readonly: assert property (
    (spr_req.wr && !dp_req.wr && !test_clr) |=> $stable(edm_q))
    else $error("software write changed edm");

  chk_edm_first_set: assert property (
    (!edm_q && dp_req.wr && dp_req.sel == dbgc_pkg::SEL_CTL0 &&
     dp_req.data[dbgc_pkg::POS_EDM] && pin_lvl[dbgc_pkg::PIN_PROC] && !test_clr)
      |=> (edm_q && $stable(regs_q[dbgc_pkg::SEL_CTL0])))
    else $error("first edm set disturbed other control bits");

  chk_proc_reset_edm: assert property (
    (!pin_lvl[dbgc_pkg::PIN_PROC] && !test_clr && !dp_req.wr)
      |=> ($stable(edm_q) && regs_q == '0))
    else $error("processor reset handling wrong");

  chk_status_gate: assert property (
    (!idm_q && !edm_q && !dp_req.wr && !spr_req.wr && pin_lvl[dbgc_pkg::PIN_PROC])
      |=> $stable(regs_q[dbgc_pkg::SEL_STAT]))
    else $error("status changed with both debug modes off");

  chk_no_vector_edm: assert property (
    edm_q |=> !debug_int_q)
    else $error("debug interrupt raised in external debug mode");

  chk_int_recorded: assert property (
    (idm_q && machine_state_debug_enable && !edm_q && (|regs_q[dbgc_pkg::SEL_STAT]))
      |=> debug_int_q)
    else $error("recorded event did not raise debug interrupt");

  chk_reset_out: assert property (
    (ctl0[dbgc_pkg::POS_RST +: 2] == dbgc_pkg::RST_ASSERT) [*2] |-> !reset_out_n_q)
    else $error("reset-out not asserted for field value 10");

  chk_reserved_zero: assert property (
    (ctl0 & ~dbgc_pkg::CTL0_WR_MASK) == 32'h0000_0000)
    else $error("reserved control bit set");

  chk_trap_record: assert property (
    (rec_on && core_evt.trap && ctl0[dbgc_pkg::POS_TRAP] && pin_lvl[dbgc_pkg::PIN_PROC])
      |=> regs_q[dbgc_pkg::SEL_STAT][dbgc_pkg::POS_TRAP])
    else $error("enabled trap event not recorded");

  chk_watch_indep: assert property (
    (fetch_valid && m12 == dbgc_pkg::MODE_EXACT && iaddr == iac_m[0]) |=> watchpoint_q[0])
    else $error("watchpoint missing for instruction compare one");

endmodule : dbgc_top

// ==== core/dbgc_pkg.sv ====
// Shared constants and carrier types for the debug control block
package dbgc_pkg;

  localparam int unsigned DW   = 32;
  localparam int unsigned NREG = 11;

  typedef logic [3:0]    dbgc_sel_t;
  typedef logic [DW-1:0] dbgc_word_t;

  // Debug register select codes
  localparam dbgc_sel_t SEL_CTL0 = 4'h0;
  localparam dbgc_sel_t SEL_CTL1 = 4'h1;
  localparam dbgc_sel_t SEL_CTL2 = 4'h2;
  localparam dbgc_sel_t SEL_STAT = 4'h3;
  localparam dbgc_sel_t SEL_CNT  = 4'h4;
  localparam dbgc_sel_t SEL_INSTR_ADDR_COMPARE_ONE = 4'h5;
  localparam dbgc_sel_t SEL_INSTR_ADDR_COMPARE_TWO = 4'h6;
  localparam dbgc_sel_t SEL_INSTR_ADDR_COMPARE_THREE = 4'h7;
  localparam dbgc_sel_t SEL_INSTR_ADDR_COMPARE_FOUR = 4'h8;
  localparam dbgc_sel_t SEL_DATA_ADDR_COMPARE_ONE = 4'h9;
  localparam dbgc_sel_t SEL_DATA_ADDR_COMPARE_TWO = 4'ha;

  // Control zero field positions, bit 0 is the word LSB
  localparam int unsigned POS_EDM   = 0;
  localparam int unsigned POS_IDM   = 1;
  localparam int unsigned POS_RST   = 2;
  localparam int unsigned POS_INSTR_COMPLETE_EVENT_ENABLE  = 4;
  localparam int unsigned POS_BRT   = 5;
  localparam int unsigned POS_INTERRUPT_TAKEN_EVENT_ENABLE  = 6;
  localparam int unsigned POS_TRAP  = 7;
  localparam int unsigned POS_INSTR_ADDR_COMPARE_ONE  = 8;
  localparam int unsigned POS_DATA_ADDR_COMPARE_ONE  = 12;
  localparam int unsigned POS_DATA_ADDR_COMPARE_TWO  = 14;
  localparam int unsigned POS_RET   = 16;
  localparam int unsigned POS_EXTERNAL_EVENT_ONE_ENABLE = 21;
  localparam int unsigned POS_EXTERNAL_EVENT_TWO_ENABLE = 22;
  localparam int unsigned POS_CRITICAL_INTERRUPT_EVENT_ENABLE = 25;
  localparam int unsigned POS_CRITICAL_RETURN_EVENT_ENABLE  = 26;

  // Compare mode fields in control one and two
  localparam int unsigned POS_IM12 = 8;
  localparam int unsigned POS_IM34 = 24;
  localparam int unsigned POS_DM12 = 8;

  localparam logic [1:0] RST_ASSERT = 2'h2;
  localparam logic [1:0] MODE_EXACT = 2'h0;
  localparam logic [1:0] MODE_BITM  = 2'h1;
  localparam logic [1:0] MODE_INCL  = 2'h2;
  localparam logic [1:0] MODE_EXCL  = 2'h3;

  // Writable control zero bits, edm excluded; status event bits
  localparam dbgc_word_t CTL0_WR_MASK = 32'h0661_fffe;
  localparam dbgc_word_t STAT_MASK    = 32'h0661_5ff0;
  localparam dbgc_word_t REG_RESET    = 32'h0000_0000;
  localparam dbgc_word_t IADDR_KEEP   = 32'hffff_fffe;

  // Pin synchroniser lanes
  localparam int unsigned NPIN      = 5;
  localparam int unsigned PIN_PROC  = 0;
  localparam int unsigned PIN_TEST  = 1;
  localparam int unsigned PIN_TAP   = 2;
  localparam int unsigned PIN_EV1   = 3;
  localparam logic [NPIN-1:0] PIN_IDLE = 5'h03;

  typedef struct packed {
    logic       wr;
    logic       rd;
    dbgc_sel_t  sel;
    dbgc_word_t data;
  } dbgc_req_s;

  typedef struct packed {
    logic instr_complete_event_enable;
    logic branch_taken_event_enable;
    logic interrupt_taken_event_enable;
    logic trap;
    logic ret;
    logic critical_interrupt_event_enable;
    logic critical_return_event_enable;
  } dbgc_evt_s;

endpackage : dbgc_pkg

// ==== core/dbgc_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module dbgc_pin_sync #(
  parameter int unsigned    W    = 5,
  parameter logic [W-1:0]   IDLE = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_d;

  // Level moves only on_chip_debug_port stages two and three agree
  for (genvar i = 0; i < W; i++)
  begin : g_lane
    assign level_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : level_q[i];
  end

  // Register chain
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_q    <= IDLE;
      s2_q    <= IDLE;
      s3_q    <= IDLE;
      level_q <= IDLE;
    end
    else
    begin
      s1_q    <= pin_in;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
    end
  end

endmodule : dbgc_pin_sync

// ==== test/dbgc_dbg_model.sv ====
// External debugger model on the debug port side
`timescale 1ns/10ps
module dbgc_dbg_model (
  input  wire logic           ref_clk,
  output dbgc_pkg::dbgc_req_s dp_req
);
  // Idle port at time zero
  initial
  begin
    dp_req = '0;
  end

  // One access held over one rising edge, select and data inverted on release
  task automatic access(input logic wr, input dbgc_pkg::dbgc_sel_t sel,
                        input dbgc_pkg::dbgc_word_t data);
    @(negedge ref_clk);
    dp_req.wr   = wr;
    dp_req.rd   = ~wr;
    dp_req.sel  = sel;
    dp_req.data = data;
    @(negedge ref_clk);
    dp_req.wr   = 1'b0;
    dp_req.rd   = 1'b0;
    dp_req.sel  = ~sel;
    dp_req.data = ~data;
  endtask : access

  // Take over the debug registers, mode bit alone first
  task automatic take();
    access(1'b1, dbgc_pkg::SEL_CTL0, 32'h0000_0001);
  endtask : take

  // Register write while in control
  task automatic write(input dbgc_pkg::dbgc_sel_t sel, input dbgc_pkg::dbgc_word_t data);
    access(1'b1, sel, data);
  endtask : write

  // Register read
  task automatic read(input dbgc_pkg::dbgc_sel_t sel);
    access(1'b0, sel, 32'h0000_0000);
  endtask : read

  // Hand back control: status flags cleared before the mode bit drops
  task automatic release_ctl(input dbgc_pkg::dbgc_word_t ctl);
    access(1'b1, dbgc_pkg::SEL_STAT, 32'hffff_ffff);
    access(1'b1, dbgc_pkg::SEL_CTL0, ctl & 32'hffff_fffe);
  endtask : release_ctl
endmodule : dbgc_dbg_model

// ==== test/test_debug_control_register_gating.sv ====
// Self-checking bench for the debug control register gating block
`timescale 1ns/10ps
module test_debug_control_register_gating;
  logic                 ref_clk, arst_n, proc_rst_n_pin, test_rst_n_pin;
  logic                 tap_logic_reset_pin, machine_state_debug_enable;
  logic                 fetch_valid, data_valid, data_is_store;
  logic [1:0]           ext_evt_pin;
  logic [31:0]          fetch_addr, data_addr, seed;
  dbgc_pkg::dbgc_req_s  spr_req, dp_req;
  dbgc_pkg::dbgc_evt_s  core_evt;
  logic [31:0]          spr_rdata_q, dp_rdata_q;
  logic                 reset_out_n_q, debug_int_q, ext_debug_event_q;
  logic [5:0]           watchpoint_q;
  dbgc_pkg::dbgc_word_t exp_q[$];
  int                   bad_count = 0;
  int                   check_count = 0;

  dbgc_top dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .proc_rst_n_pin(proc_rst_n_pin),
    .test_rst_n_pin(test_rst_n_pin), .tap_logic_reset_pin(tap_logic_reset_pin),
    .ext_evt_pin(ext_evt_pin), .spr_req(spr_req), .dp_req(dp_req), .core_evt(core_evt),
    .machine_state_debug_enable(machine_state_debug_enable), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .data_valid(data_valid), .data_is_store(data_is_store),
    .data_addr(data_addr), .spr_rdata_q(spr_rdata_q), .dp_rdata_q(dp_rdata_q),
    .reset_out_n_q(reset_out_n_q), .debug_int_q(debug_int_q),
    .ext_debug_event_q(ext_debug_event_q), .watchpoint_q(watchpoint_q)
  );

  dbgc_dbg_model dbg (
    .ref_clk(ref_clk),
    .dp_req(dp_req)
  );

  // Free-running core clock
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Verdict and end of run
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Xorshift stimulus source
  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : next_rand

  // Software access held over one rising edge
  task automatic spr(input logic wr, input dbgc_pkg::dbgc_sel_t sel,
                     input dbgc_pkg::dbgc_word_t data);
    @(negedge ref_clk);
    spr_req.wr   = wr;
    spr_req.rd   = ~wr;
    spr_req.sel  = sel;
    spr_req.data = data;
    @(negedge ref_clk);
    spr_req.wr   = 1'b0;
    spr_req.rd   = 1'b0;
    spr_req.sel  = ~sel;
    spr_req.data = ~data;
  endtask : spr

  task automatic wr_s(input dbgc_pkg::dbgc_sel_t sel, input dbgc_pkg::dbgc_word_t data);
    spr(1'b1, sel, data);
  endtask : wr_s

  task automatic rd_s(input dbgc_pkg::dbgc_sel_t sel, input dbgc_pkg::dbgc_word_t exp);
    exp_q.push_back(exp);
    spr(1'b0, sel, 32'h0000_0000);
  endtask : rd_s

  task automatic rd_d(input dbgc_pkg::dbgc_sel_t sel, input dbgc_pkg::dbgc_word_t exp);
    exp_q.push_back(exp);
    dbg.read(sel);
  endtask : rd_d

  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : step

  // One cycle of fetch and data compare inputs
  task automatic probe(input logic fv, input logic [31:0] fa, input logic dv,
                       input logic st, input logic [31:0] da);
    fetch_valid   = fv;
    fetch_addr    = fa;
    data_valid    = dv;
    data_is_store = st;
    data_addr     = da;
    step(1);
    fetch_valid   = 1'b0;
    data_valid    = 1'b0;
  endtask : probe

  // Read result watcher, oldest note first
  initial
  begin : monitor
    logic sr, dr;
    forever
    begin
      @(posedge ref_clk);
      sr = spr_req.rd;
      dr = dp_req.rd;
      @(negedge ref_clk);
      if (sr) check(spr_rdata_q, exp_q.pop_front());
      if (dr) check(dp_rdata_q, exp_q.pop_front());
    end
  end

  // Hang guard
  initial
  begin
    repeat (4000) @(posedge ref_clk);
    bad_count++;
    end_of_test();
  end

  // Main sequence
  initial
  begin : main
    int          pos [7];
    logic [31:0] r;
    pos = '{4, 5, 6, 7, 16, 25, 26};
    {arst_n, tap_logic_reset_pin, machine_state_debug_enable} = 3'b000;
    {proc_rst_n_pin, test_rst_n_pin} = 2'b11;
    {fetch_valid, data_valid, data_is_store, ext_evt_pin} = 5'h00;
    {fetch_addr, data_addr} = 64'h0;
    spr_req = '0;
    core_evt = '0;
    seed = 32'h0000_0013;
    step(10);
    arst_n = 1'b1;
    step(4);
    // All-ones software write: mode bit and reserved bits stay clear
    wr_s(dbgc_pkg::SEL_CTL0, 32'hffff_ffff);
    rd_s(dbgc_pkg::SEL_CTL0, 32'h0661_fffe);
    // Every reset control code
    for (int v = 0; v < 4; v++)
    begin
      wr_s(dbgc_pkg::SEL_CTL0, 32'(v) << 2);
      step(1);
      check({31'h0, reset_out_n_q}, {31'h0, v != 2});
    end
    // Each core event, enabled and disabled
    machine_state_debug_enable = 1'b1;
    for (int i = 0; i < 14; i++)
    begin
      wr_s(dbgc_pkg::SEL_CTL0, 32'h2 | (32'(i % 2) << pos[i / 2]));
      core_evt = dbgc_pkg::dbgc_evt_s'(7'h40 >> (i / 2));
      step(1);
      core_evt = '0;
      check({31'h0, debug_int_q}, 32'(i % 2));
      rd_s(dbgc_pkg::SEL_STAT, 32'(i % 2) << pos[i / 2]);
      wr_s(dbgc_pkg::SEL_STAT, 32'hffff_ffff);
    end
    // Event recorded with state enable clear, interrupt on_chip_debug_port it is set
    machine_state_debug_enable = 1'b0;
    wr_s(dbgc_pkg::SEL_CTL0, 32'h0000_0012);
    core_evt = dbgc_pkg::dbgc_evt_s'(7'h40);
    step(1);
    core_evt = '0;
    check({31'h0, debug_int_q}, 32'h0);
    machine_state_debug_enable = 1'b1;
    step(1);
    check({31'h0, debug_int_q}, 32'h1);
    wr_s(dbgc_pkg::SEL_STAT, 32'hffff_ffff);
    // External event inputs
    for (int i = 0; i < 2; i++)
    begin
      wr_s(dbgc_pkg::SEL_CTL0, 32'h2 | (32'h1 << (21 + i)));
      ext_evt_pin[i] = 1'b1;
      step(8);
      ext_evt_pin = 2'b00;
      rd_s(dbgc_pkg::SEL_STAT, 32'h1 << (21 + i));
      wr_s(dbgc_pkg::SEL_STAT, 32'hffff_ffff);
    end
    // Data compare access types, watchpoint regardless of enable
    r = next_rand();
    wr_s(dbgc_pkg::SEL_DATA_ADDR_COMPARE_ONE, r);
    for (int i = 0; i < 8; i++)
    begin
      wr_s(dbgc_pkg::SEL_CTL0, 32'h2 | (32'(i / 2) << 12));
      probe(1'b0, 32'h0, 1'b1, 1'(i % 2), r);
      check({31'h0, watchpoint_q[4]}, 32'h1);
      rd_s(dbgc_pkg::SEL_STAT, ((32'(i / 2) >> (1 - i % 2)) & 32'h1) << 12);
      wr_s(dbgc_pkg::SEL_STAT, 32'hffff_ffff);
    end
    // Instruction compare ignores the lowest bit
    r = next_rand();
    wr_s(dbgc_pkg::SEL_CTL0, 32'h0000_0102);
    wr_s(dbgc_pkg::SEL_INSTR_ADDR_COMPARE_ONE, r | 32'h1);
    probe(1'b1, r & 32'hffff_fffe, 1'b0, 1'b0, 32'h0);
    check({31'h0, watchpoint_q[0]}, 32'h1);
    rd_s(dbgc_pkg::SEL_STAT, 32'h0000_0100);
    // Bit-match modes, second register as mask
    wr_s(dbgc_pkg::SEL_CTL1, 32'h0000_0100);
    wr_s(dbgc_pkg::SEL_INSTR_ADDR_COMPARE_TWO, 32'hffff_0000);
    wr_s(dbgc_pkg::SEL_INSTR_ADDR_COMPARE_ONE, 32'h1234_0000);
    probe(1'b1, 32'h1234_0000 | (next_rand() & 32'hffff), 1'b0, 1'b0, 32'h0);
    check({30'h0, watchpoint_q[1:0]}, 32'h1);
    probe(1'b1, 32'h5678_0000, 1'b0, 1'b0, 32'h0);
    check({30'h0, watchpoint_q[1:0]}, 32'h0);
    // Range modes on the third and fourth pair
    wr_s(dbgc_pkg::SEL_INSTR_ADDR_COMPARE_THREE, 32'h0000_1000);
    wr_s(dbgc_pkg::SEL_INSTR_ADDR_COMPARE_FOUR, 32'h0000_2000);
    wr_s(dbgc_pkg::SEL_CTL1, 32'h0200_0100);
    probe(1'b1, 32'h0000_1800, 1'b0, 1'b0, 32'h0);
    check({28'h0, watchpoint_q[3:0]}, 32'h4);
    wr_s(dbgc_pkg::SEL_CTL1, 32'h0300_0100);
    probe(1'b1, 32'h0000_1800, 1'b0, 1'b0, 32'h0);
    check({28'h0, watchpoint_q[3:0]}, 32'h0);
    probe(1'b1, 32'h0000_2800, 1'b0, 1'b0, 32'h0);
    check({28'h0, watchpoint_q[3:0]}, 32'h4);
    wr_s(dbgc_pkg::SEL_CTL1, 32'h0000_0100);
    wr_s(dbgc_pkg::SEL_CTL2, 32'h0000_0100);
    wr_s(dbgc_pkg::SEL_DATA_ADDR_COMPARE_TWO, 32'hffff_ff00);
    wr_s(dbgc_pkg::SEL_DATA_ADDR_COMPARE_ONE, 32'habcd_ef00);
    probe(1'b0, 32'h0, 1'b1, 1'b1, 32'habcd_ef00 | (next_rand() & 32'hff));
    check({26'h0, watchpoint_q[5:4], 4'h0}, 32'h10);
    // Debugger takes control: software writes ignored
    wr_s(dbgc_pkg::SEL_STAT, 32'hffff_ffff);
    wr_s(dbgc_pkg::SEL_CTL0, 32'h0000_0012);
    wr_s(dbgc_pkg::SEL_INSTR_ADDR_COMPARE_ONE, 32'h0000_0040);
    dbg.take();
    rd_d(dbgc_pkg::SEL_CTL0, 32'h0000_0013);
    wr_s(dbgc_pkg::SEL_CTL0, 32'h0000_0000);
    wr_s(dbgc_pkg::SEL_INSTR_ADDR_COMPARE_ONE, 32'h0000_0080);
    rd_s(dbgc_pkg::SEL_CTL0, 32'h0000_0013);
    rd_s(dbgc_pkg::SEL_INSTR_ADDR_COMPARE_ONE, 32'h0000_0040);
    core_evt = dbgc_pkg::dbgc_evt_s'(7'h40);
    step(1);
    core_evt = '0;
    check({30'h0, debug_int_q, ext_debug_event_q}, 32'h1);
    dbg.write(dbgc_pkg::SEL_INSTR_ADDR_COMPARE_ONE, 32'h0000_0100);
    rd_d(dbgc_pkg::SEL_INSTR_ADDR_COMPARE_ONE, 32'h0000_0100);
    dbg.release_ctl(32'h0000_0012);
    rd_s(dbgc_pkg::SEL_STAT, 32'h0000_0000);
    check({31'h0, debug_int_q}, 32'h0);
    // Mode bit survives processor reset, cleared by test reset and logic-reset state
    dbg.take();
    proc_rst_n_pin = 1'b0;
    step(6);
    proc_rst_n_pin = 1'b1;
    step(6);
    rd_s(dbgc_pkg::SEL_CTL0, 32'h0000_0001);
    for (int i = 0; i < 2; i++)
    begin
      dbg.take();
      {test_rst_n_pin, tap_logic_reset_pin} = (i == 0) ? 2'b00 : 2'b11;
      step(6);
      {test_rst_n_pin, tap_logic_reset_pin} = 2'b10;
      step(6);
      rd_s(dbgc_pkg::SEL_CTL0, 32'h0000_0000);
    end
    step(2);
    end_of_test();
  end
endmodule : test_debug_control_register_gating
